// ===== src/gpio_map.svh
// Register offsets, field positions and reset values of the GPIO block.
// Assumes a 32-bit Wishbone slave, one register per aligned word.
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_FIRST_DATA 8'h00
`define OFS_FIRST_DIR 8'h04
`define OFS_CHANGE_DATA 8'h08
`define OFS_CHANGE_DIR 8'h0C
`define OFS_SDATA_DATA 8'h10
`define OFS_SDATA_DIR 8'h14
`define OFS_SCTRL_DATA 8'h18
`define OFS_SCTRL_DIR 8'h1C
`define OFS_OPTION 8'h20
`define OFS_INTCTRL 8'h24
`define OFS_ANALOG_SEL 8'h28
`define OFS_CMP_CTRL 8'h2C
`define OFS_SEG_EN 8'h30
`define OFS_BIT_OP 8'h34

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define OPT_PULLUP_N_BIT 7
`define INTC_FLAG_BIT 0
`define INTC_CHG_EN_BIT 3
`define SCTRL_MODE_BIT 4
`define SCTRL_OVF_BIT 5
`define SCTRL_OBF_BIT 6
`define SCTRL_IBF_BIT 7
`define BITOP_IDX_LSB 0
`define BITOP_PORT_LSB 4
`define BITOP_VAL_BIT 7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DIR_RST 8'hFF
`define SCTRL_DIR_RST 8'h07
`define OPTION_RST 8'h80
`define INTCTRL_RST 8'h00
`define ANALOG_SEL_RST 8'hFF
`define CMP_CTRL_RST 8'h0F
`define SEG_EN_RST 8'hFF

`endif

// ===== src/gpio_pkg.sv
// Types shared by the GPIO block.
// Assumes gpio_map.svh supplies the numeric constants.
package gpio_pkg;

    // ------------------------------------------------------------------
    // Target port of a bit set or bit clear operation
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PORT_FIRST,
        PORT_CHANGE,
        PORT_SDATA,
        PORT_SCTRL
    } port_sel_t;

endpackage : gpio_pkg

// ===== src/gpio_port.sv
// GPIO port block: four ports, change detect, parallel slave port.
// Assumes a classic Wishbone master on clk_i; pads resolved outside.
`include "gpio_map.svh"
`timescale 1ns/10ps
`default_nettype none

// Operation
// R1 - Direction one releases pin, zero drives latch
// R2 - Port read returns pin levels
// R3 - Writes load latch; bit ops modify pins
// R4 - Reset gives shared pins to peripherals
// R5 - Enabled peripherals override direction bits
// R6 - Analog select chooses analog; reads zero
// R7 - Direction still drives analog pins
// R8 - Reset makes converter pins analog
// R9 - Reset makes comparator pins analog, read zero
// R10 - Segment enables override direction; reset set
// R11 - Parallel slave mode overrides data direction
// R12 - Slave port bits in control direction
// R13 - Special pin open-drain; others push-pull
// R14 - Change port eight bits, own direction
// R15 - Low option bit enables all pull-ups
// R16 - Pull-up off on output pins
// R17 - Reset leaves pull-ups off
// R18 - Upper four pins mismatch sets change flag
// R19 - Output pins excluded from mismatch
// R20 - Change condition can wake from sleep
// R21 - Mismatch keeps setting; access refreshes copy
// R22 - Software should not poll change port
// R23 - Write zero clears flag; set wins
// R24 - Reset makes all inputs; latches hold
module gpio_port #(
    parameter int FIRST_W = 6,
    parameter int CTRL_W = 3,
    parameter int OD_PIN = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [FIRST_W-1:0] first_pad_i,
    output logic [FIRST_W-1:0] first_pad_o,
    output logic [FIRST_W-1:0] first_pad_oe_o,
    input wire logic [7:0] change_pad_i,
    output logic [7:0] change_pad_o,
    output logic [7:0] change_pad_oe_o,
    output logic [7:0] change_pullup_o,
    input wire logic [7:0] sdata_pad_i,
    output logic [7:0] sdata_pad_o,
    output logic [7:0] sdata_pad_oe_o,
    input wire logic [CTRL_W-1:0] sctrl_pad_i,
    output logic [CTRL_W-1:0] sctrl_pad_o,
    output logic [CTRL_W-1:0] sctrl_pad_oe_o,
    input wire logic [7:0] seg_drive_i,
    input wire logic sleep_i,
    output logic wake_o
);

    // ------------------------------------------------------------------
    // Bus access
    // ------------------------------------------------------------------
    logic ack;
    logic acc;
    logic wr;
    logic rd;

    // A request is served on the edge where the master sees ack
    assign acc = cyc_i & stb_i & ack;
    assign wr = acc & we_i & sel_i[0];
    assign rd = acc & ~we_i;
    assign ack_o = ack;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack <= 1'b0;
        else
            ack <= cyc_i & stb_i & ~ack;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] latch_a;
    logic [7:0] latch_b;
    logic [7:0] latch_d;
    logic [7:0] latch_e;
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_d;
    logic [7:0] dir_e;
    logic [7:0] option;
    logic chg_en;
    logic chg_flag;
    logic [7:0] analog_sel;
    logic [7:0] cmp_ctrl;
    logic [7:0] seg_en;
    logic [3:0] chg_copy;
    logic [7:0] psp_in;
    logic psp_ibf;
    logic psp_obf;
    logic psp_ovf;
    logic psp_wr_prev;
    logic psp_rd_prev;

    logic [FIRST_W-1:0] lvl_a;
    logic [7:0] lvl_b;
    logic [7:0] lvl_d;
    logic [CTRL_W-1:0] lvl_e;

    logic [7:0] lvl_a8;
    logic [7:0] lvl_e8;
    assign lvl_a8 = 8'(lvl_a);
    assign lvl_e8 = 8'(lvl_e);

    // ------------------------------------------------------------------
    // Bit set / clear on sampled pin levels
    // ------------------------------------------------------------------
    logic bitop;
    gpio_pkg::port_sel_t bop_port;
    logic [2:0] bop_idx;
    logic bop_val;

    assign bitop = wr & (adr_i == `OFS_BIT_OP);
    assign bop_port = gpio_pkg::port_sel_t'(dat_i[`BITOP_PORT_LSB +: 2]);
    assign bop_idx = dat_i[`BITOP_IDX_LSB +: 3];
    assign bop_val = dat_i[`BITOP_VAL_BIT];

    function automatic logic [7:0] bit_mod(
        input logic [7:0] v,
        input logic [2:0] idx,
        input logic val
    );
        logic [7:0] r;
        r = v;
        r[idx] = val;
        return r;
    endfunction : bit_mod

    logic mode;
    assign mode = dir_e[`SCTRL_MODE_BIT];

    // Latches are not reset: they hold until software writes them
    always_ff @(posedge clk_i)
    begin
        if (wr && adr_i == `OFS_FIRST_DATA)
            latch_a <= dat_i[7:0]; // R3 R24
        else if (bitop && bop_port == gpio_pkg::PORT_FIRST)
            latch_a <= bit_mod(lvl_a8, bop_idx, bop_val); // R3
        if (wr && adr_i == `OFS_CHANGE_DATA)
            latch_b <= dat_i[7:0]; // R3
        else if (bitop && bop_port == gpio_pkg::PORT_CHANGE)
            latch_b <= bit_mod(lvl_b, bop_idx, bop_val); // R3
        if (wr && adr_i == `OFS_SDATA_DATA)
            latch_d <= dat_i[7:0]; // R3
        else if (bitop && bop_port == gpio_pkg::PORT_SDATA)
            latch_d <= bit_mod(lvl_d, bop_idx, bop_val); // R3
        if (wr && adr_i == `OFS_SCTRL_DATA)
            latch_e <= dat_i[7:0]; // R3
        else if (bitop && bop_port == gpio_pkg::PORT_SCTRL)
            latch_e <= bit_mod(lvl_e8, bop_idx, bop_val); // R3
    end

    // Direction and configuration registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dir_a <= `DIR_RST; // R24
            dir_b <= `DIR_RST; // R14 R24
            dir_d <= `DIR_RST;
            option <= `OPTION_RST; // R17
            chg_en <= 1'b0;
            analog_sel <= `ANALOG_SEL_RST; // R4 R8
            cmp_ctrl <= `CMP_CTRL_RST; // R9
            seg_en <= `SEG_EN_RST; // R4 R10
        end
        else if (wr)
        begin
            unique case (adr_i)
                `OFS_FIRST_DIR: dir_a <= dat_i[7:0];
                `OFS_CHANGE_DIR: dir_b <= dat_i[7:0]; // R14
                `OFS_SDATA_DIR: dir_d <= dat_i[7:0];
                `OFS_OPTION: option <= dat_i[7:0]; // R15
                `OFS_INTCTRL: chg_en <= dat_i[`INTC_CHG_EN_BIT];
                `OFS_ANALOG_SEL: analog_sel <= dat_i[7:0]; // R6
                `OFS_CMP_CTRL: cmp_ctrl <= dat_i[7:0];
                `OFS_SEG_EN: seg_en <= dat_i[7:0]; // R10
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Slave control direction register with slave port status
    // ------------------------------------------------------------------
    logic psp_cs;
    logic psp_wr_act;
    logic psp_rd_act;
    logic sctrl_dir_wr;
    logic sdata_rd;

    // Control pins are active low: chip select, write, read
    assign psp_cs = mode & ~lvl_e8[2]; // R11
    assign psp_wr_act = psp_cs & ~lvl_e8[1];
    assign psp_rd_act = psp_cs & ~lvl_e8[0];
    assign sctrl_dir_wr = wr & (adr_i == `OFS_SCTRL_DIR);
    assign sdata_rd = rd & (adr_i == `OFS_SDATA_DATA);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dir_e <= `SCTRL_DIR_RST; // R24
        else if (sctrl_dir_wr)
            dir_e[`SCTRL_MODE_BIT:0] <= dat_i[`SCTRL_MODE_BIT:0]; // R12
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            psp_wr_prev <= 1'b0;
            psp_rd_prev <= 1'b0;
        end
        else
        begin
            psp_wr_prev <= psp_wr_act;
            psp_rd_prev <= psp_rd_act;
        end
    end

    // Status flags: set wins over clear; IBF and OVF are set by hardware, OBF by a data write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            psp_ibf <= 1'b0;
            psp_obf <= 1'b0;
            psp_ovf <= 1'b0;
        end
        else
        begin
            if (psp_wr_act && !psp_wr_prev)
                psp_ibf <= 1'b1; // R12
            else if (sdata_rd)
                psp_ibf <= 1'b0;
            if (mode && wr && adr_i == `OFS_SDATA_DATA)
                psp_obf <= 1'b1; // R12
            else if (!psp_rd_act && psp_rd_prev)
                psp_obf <= 1'b0;
            if (psp_wr_act && !psp_wr_prev && psp_ibf)
                psp_ovf <= 1'b1; // R12
            else if (sctrl_dir_wr && !dat_i[`SCTRL_OVF_BIT])
                psp_ovf <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            psp_in <= 8'h00;
        else if (psp_wr_act && !psp_wr_prev)
            psp_in <= sdata_pad_i;
    end

    // ------------------------------------------------------------------
    // Change detect on the upper four change port pins
    // ------------------------------------------------------------------
    logic chg_access;
    logic mismatch;
    logic flag_clr;

    assign chg_access = (acc && adr_i == `OFS_CHANGE_DATA)
        || (bitop && bop_port == gpio_pkg::PORT_CHANGE); // R21
    // Only input pins take part
    assign mismatch = |((lvl_b[7:4] ^ chg_copy) & dir_b[7:4]); // R18 R19
    assign flag_clr = wr && adr_i == `OFS_INTCTRL
        && !dat_i[`INTC_FLAG_BIT];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            chg_copy <= 4'h0;
        else if (chg_access)
            chg_copy <= lvl_b[7:4]; // R21 R22
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            chg_flag <= 1'b0;
        else if (mismatch)
            chg_flag <= 1'b1; // R18 R21 R23
        else if (flag_clr)
            chg_flag <= 1'b0; // R23
    end

    // Works without the clock being gated by sleep
    assign wake_o = sleep_i & chg_en & (chg_flag | mismatch); // R20

    // ------------------------------------------------------------------
    // Pull-ups
    // ------------------------------------------------------------------
    // Active-low enable; outputs never see a pull-up
    assign change_pullup_o = {8{~option[`OPT_PULLUP_N_BIT]}} & dir_b;
    // R15 R16

    // ------------------------------------------------------------------
    // Pin banks
    // ------------------------------------------------------------------
    logic [FIRST_W-1:0] analog_a;
    logic [7:0] ovr_en_d;
    logic [7:0] ovr_oe_d;
    logic [7:0] ovr_out_d;

    // Direction bits keep driving analog pins; only the read is masked
    assign analog_a = FIRST_W'(analog_sel) | FIRST_W'(cmp_ctrl[3:0]);
    // R6 R7 R9
    // Segment drivers take priority over the slave port
    assign ovr_en_d = seg_en | {8{mode}}; // R10 R11
    assign ovr_oe_d = seg_en | {8{psp_rd_act}}; // R5 R11
    assign ovr_out_d = (seg_en & seg_drive_i) | (~seg_en & latch_d);

    pin_bank #(
        .WIDTH(FIRST_W),
        .OD_MASK(FIRST_W'(1) << OD_PIN)
    ) u_first (
        .latch_i(latch_a[FIRST_W-1:0]),
        .dir_i(dir_a[FIRST_W-1:0]),
        .ovr_en_i('0),
        .ovr_oe_i('0),
        .ovr_out_i('0),
        .analog_i(analog_a),
        .pad_i(first_pad_i),
        .pad_o(first_pad_o),
        .pad_oe_o(first_pad_oe_o),
        .level_o(lvl_a)
    );

    pin_bank #(
        .WIDTH(8),
        .OD_MASK(8'h00)
    ) u_change (
        .latch_i(latch_b),
        .dir_i(dir_b),
        .ovr_en_i(8'h00),
        .ovr_oe_i(8'h00),
        .ovr_out_i(8'h00),
        .analog_i(8'h00),
        .pad_i(change_pad_i),
        .pad_o(change_pad_o),
        .pad_oe_o(change_pad_oe_o),
        .level_o(lvl_b)
    );

    pin_bank #(
        .WIDTH(8),
        .OD_MASK(8'h00)
    ) u_sdata (
        .latch_i(latch_d),
        .dir_i(dir_d),
        .ovr_en_i(ovr_en_d),
        .ovr_oe_i(ovr_oe_d),
        .ovr_out_i(ovr_out_d),
        .analog_i(8'h00),
        .pad_i(sdata_pad_i),
        .pad_o(sdata_pad_o),
        .pad_oe_o(sdata_pad_oe_o),
        .level_o(lvl_d)
    );

    pin_bank #(
        .WIDTH(CTRL_W),
        .OD_MASK('0)
    ) u_sctrl (
        .latch_i(latch_e[CTRL_W-1:0]),
        .dir_i(dir_e[CTRL_W-1:0]),
        .ovr_en_i('0),
        .ovr_oe_i('0),
        .ovr_out_i('0),
        .analog_i('0),
        .pad_i(sctrl_pad_i),
        .pad_o(sctrl_pad_o),
        .pad_oe_o(sctrl_pad_oe_o),
        .level_o(lvl_e)
    );

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [7:0] next_rdata;

    always_comb
    begin
        unique case (adr_i)
            `OFS_FIRST_DATA: next_rdata = lvl_a8; // R2
            `OFS_FIRST_DIR: next_rdata = dir_a;
            `OFS_CHANGE_DATA: next_rdata = lvl_b; // R2
            `OFS_CHANGE_DIR: next_rdata = dir_b;
            `OFS_SDATA_DATA: next_rdata = mode ? psp_in : lvl_d;
            `OFS_SDATA_DIR: next_rdata = dir_d;
            `OFS_SCTRL_DATA: next_rdata = lvl_e8;
            `OFS_SCTRL_DIR: next_rdata = {psp_ibf, psp_obf, psp_ovf,
                dir_e[`SCTRL_MODE_BIT:0]}; // R12
            `OFS_OPTION: next_rdata = option;
            `OFS_INTCTRL: next_rdata = {4'h0, chg_en, 2'h0, chg_flag};
            `OFS_ANALOG_SEL: next_rdata = analog_sel;
            `OFS_CMP_CTRL: next_rdata = cmp_ctrl;
            `OFS_SEG_EN: next_rdata = seg_en;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h0000_0000;
        else if (cyc_i && stb_i && !ack)
            dat_o <= {24'h00_0000, next_rdata};
    end

endmodule : gpio_port

`default_nettype wire

// ===== src/pin_bank.sv
// One bank of port pins: output drive, enable and input read-back.
// Assumes pad inputs are synchronous to the core clock.
`timescale 1ns/10ps
`default_nettype none

module pin_bank #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] OD_MASK = '0
) (
    input wire logic [WIDTH-1:0] latch_i,
    input wire logic [WIDTH-1:0] dir_i,
    input wire logic [WIDTH-1:0] ovr_en_i,
    input wire logic [WIDTH-1:0] ovr_oe_i,
    input wire logic [WIDTH-1:0] ovr_out_i,
    input wire logic [WIDTH-1:0] analog_i,
    input wire logic [WIDTH-1:0] pad_i,
    output logic [WIDTH-1:0] pad_o,
    output logic [WIDTH-1:0] pad_oe_o,
    output logic [WIDTH-1:0] level_o
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_pin
            logic drive;
            logic value;
            // Peripheral override beats the direction bit
            assign drive = ovr_en_i[i] ? ovr_oe_i[i] : ~dir_i[i]; // R1 R5
            assign value = ovr_en_i[i] ? ovr_out_i[i] : latch_i[i];
            if (OD_MASK[i])
            begin : g_od
                // Pulls low or lets go, never drives high
                assign pad_o[i] = 1'b0; // R13
                assign pad_oe_o[i] = drive & ~value; // R13
            end
            else
            begin : g_pp
                assign pad_o[i] = drive & value; // R13
                assign pad_oe_o[i] = drive;
            end
            // Analog pins read back as zero
            assign level_o[i] = analog_i[i] ? 1'b0 : pad_i[i]; // R2 R6
        end
    endgenerate

endmodule : pin_bank

`default_nettype wire

// ===== verif/gpio_port_props.sv
// Concurrent checks on the ports of gpio_port.
// Assumes one clock domain and a classic Wishbone master.
`timescale 1ns/10ps
`default_nettype none

module gpio_port_props #(
    parameter int FIRST_W = 6,
    parameter int CTRL_W = 3,
    parameter int OD_PIN = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic [FIRST_W-1:0] first_pad_o,
    input wire logic [FIRST_W-1:0] first_pad_oe_o,
    input wire logic [7:0] change_pad_oe_o,
    input wire logic [7:0] change_pullup_o,
    input wire logic [7:0] sdata_pad_oe_o,
    input wire logic sleep_i,
    input wire logic wake_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------------
    // Bus steps
    // ------------------------------------------------------------------
    sequence bus_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence dir_wr;
        ack_o && we_i && sel_i[0] && adr_i == 8'h0C;
    endsequence
    sequence opt_wr;
        ack_o && we_i && sel_i[0] && adr_i == 8'h20;
    endsequence

    ack_latency_a: assert property (bus_req |=> ack_o)
        else $error("ack not one cycle after request");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    read_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
        else $error("upper read data not zero");
    dir_drive_a: assert property (dir_wr |=>
        change_pad_oe_o == ~$past(dat_i[7:0]))
        else $error("change port enables do not follow direction");
    pullup_out_a: assert property (
        (change_pullup_o & change_pad_oe_o) == 8'h00)
        else $error("pull-up on driven pin");
    pullup_ctl_a: assert property (opt_wr |=> change_pullup_o ==
        ($past(dat_i[7]) ? 8'h00 : ~change_pad_oe_o))
        else $error("pull-ups not set by option bit");
    od_low_a: assert property (
        first_pad_oe_o[OD_PIN] |-> !first_pad_o[OD_PIN])
        else $error("open drain pin drives high");
    wake_sleep_a: assert property (wake_o |-> sleep_i)
        else $error("wake while awake");
    reset_state_a: assert property ($fell(rst_i) |->
        first_pad_oe_o == '0 && change_pad_oe_o == 8'h00 &&
        change_pullup_o == 8'h00 && sdata_pad_oe_o == 8'hFF)
        else $error("pin state after reset wrong");
endmodule : gpio_port_props

bind gpio_port gpio_port_props #(
    .FIRST_W(FIRST_W), .CTRL_W(CTRL_W), .OD_PIN(OD_PIN)
) props (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .first_pad_o(first_pad_o),
    .first_pad_oe_o(first_pad_oe_o), .change_pad_oe_o(change_pad_oe_o),
    .change_pullup_o(change_pullup_o), .sdata_pad_oe_o(sdata_pad_oe_o),
    .sleep_i(sleep_i), .wake_o(wake_o)
);

`default_nettype wire

// ===== verif/gpio_port_with_change_detect_test.sv
// Self-checking bench for gpio_port over Wishbone and its pins.
// Assumes the checker is bound in from its own file.
`timescale 1ns/10ps
`default_nettype none

module gpio_port_with_change_detect_test;
    logic clk = 1'b0;
    logic rst, cyc, stb, we, ack, sleep, wake;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [5:0] first_in, first_o, first_oe, first_ext;
    logic [7:0] ch_in, ch_o, ch_oe, ch_pu, ch_ext;
    logic [7:0] sd_in, sd_o, sd_oe, seg;
    logic [2:0] sc_in, sc_o, sc_oe;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    // Change flag is up: pins differ from the cleared compare copy
    logic [15:0] rst_tab [11] = '{16'h04FF, 16'h0CFF, 16'h14FF,
        16'h1C07, 16'h2080, 16'h2401, 16'h28FF, 16'h2C0F, 16'h30FF,
        16'h3C00, 16'h0000};

    always #5 clk = ~clk;

    gpio_port uut (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
        .ack_o(ack), .first_pad_i(first_in), .first_pad_o(first_o),
        .first_pad_oe_o(first_oe), .change_pad_i(ch_in),
        .change_pad_o(ch_o), .change_pad_oe_o(ch_oe),
        .change_pullup_o(ch_pu), .sdata_pad_i(sd_in),
        .sdata_pad_o(sd_o), .sdata_pad_oe_o(sd_oe),
        .sctrl_pad_i(sc_in), .sctrl_pad_o(sc_o), .sctrl_pad_oe_o(sc_oe),
        .seg_drive_i(seg), .sleep_i(sleep), .wake_o(wake)
    );
    pin_env #(.W(6)) first_env (
        .clk_i(clk), .pad_o_i(first_o), .oe_i(first_oe),
        .pullup_i(6'h00), .ext_en_i(6'h3F), .ext_i(first_ext),
        .level_o(first_in)
    );
    pin_env #(.W(8)) change_env (
        .clk_i(clk), .pad_o_i(ch_o), .oe_i(ch_oe), .pullup_i(ch_pu),
        .ext_en_i(8'hFF), .ext_i(ch_ext), .level_o(ch_in)
    );

    // ------------------------------------------------------------------
    // Bus access and comparison
    // ------------------------------------------------------------------
    task automatic wb_cycle(input logic w, input logic [7:0] a,
            input logic [7:0] d, output logic [7:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        // Pins follow the ack edge only after its updates settle
        @(posedge clk);
    endtask : wb_cycle

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        wb_cycle(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] r;
        wb_cycle(1'b0, a, 8'h00, r);
        cmp(r, exp);
    endtask : rd

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // Whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_errors++;
            $display("unexpected at %0t: run hung", $time);
            wrap_up();
        end
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h00000000;
        sleep = 1'b0;
        first_ext = 6'h2B;
        ch_ext = 8'hA5;
        sd_in = 8'h00;
        sc_in = 3'h7;
        seg = 8'h3C;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (rst_tab[i])
            rd(rst_tab[i][15:8], rst_tab[i][7:0]);
        cmp(ch_pu, 8'h00);
        cmp(sd_oe, 8'hFF);
        cmp(sd_o, seg);
        $display("reset values done");

        wr(8'h28, 8'h00);
        wr(8'h2C, 8'h00);
        rd(8'h00, 8'h2B);
        wr(8'h00, 8'h15);
        wr(8'h04, 8'h00);
        cmp(8'(first_oe), 8'h2F);
        cmp(8'(first_o), 8'h05);
        rd(8'h00, 8'h05);
        wr(8'h04, 8'h3F);
        wr(8'h28, 8'h01);
        rd(8'h00, 8'h2A);
        cmp(8'(first_oe), 8'h00);
        $display("first port done");

        wr(8'h0C, 8'hF0);
        wr(8'h08, 8'h00);
        wr(8'h34, 8'h91);
        cmp(ch_o, 8'h02);
        rd(8'h08, 8'hA2);
        wr(8'h20, 8'h00);
        cmp(ch_pu, 8'hF0);
        wr(8'h20, 8'h80);
        cmp(ch_pu, 8'h00);
        $display("bit op and pull-ups done");

        wr(8'h24, 8'h08);
        rd(8'h24, 8'h08);
        ch_ext <= 8'hE5;
        repeat (2) @(posedge clk);
        sleep <= 1'b1;
        @(posedge clk);
        cmp({7'h00, wake}, 8'h01);
        rd(8'h24, 8'h09);
        wr(8'h24, 8'h08);
        rd(8'h24, 8'h09);
        sleep <= 1'b0;
        rd(8'h08, 8'hE2);
        wr(8'h24, 8'h08);
        rd(8'h24, 8'h08);
        wr(8'h0C, 8'h70);
        wr(8'h08, 8'h02);
        wr(8'h24, 8'h08);
        rd(8'h24, 8'h08);
        $display("change detect done");

        wr(8'h30, 8'h00);
        cmp(sd_oe, 8'h00);
        wr(8'h1C, 8'h17);
        cmp(8'(sc_oe), 8'h00);
        sd_in <= 8'h5A;
        sc_in <= 3'h1;
        repeat (2) @(posedge clk);
        sc_in <= 3'h7;
        rd(8'h1C, 8'h97);
        rd(8'h10, 8'h5A);
        rd(8'h1C, 8'h17);
        wr(8'h14, 8'h00);
        cmp(sd_oe, 8'h00);
        wr(8'h10, 8'hC3);
        rd(8'h1C, 8'h57);
        sc_in <= 3'h2;
        @(posedge clk);
        cmp(sd_oe, 8'hFF);
        cmp(sd_o, 8'hC3);
        sc_in <= 3'h7;
        rd(8'h1C, 8'h17);
        $display("slave port done");
        wrap_up();
    end
endmodule : gpio_port_with_change_detect_test

`default_nettype wire

// ===== verif/pin_env.sv
// External circuitry at one bank of port pins.
// Assumes the device's enable wins over the outside driver.
`timescale 1ns/10ps
`default_nettype none

module pin_env #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic [W-1:0] pad_o_i,
    input wire logic [W-1:0] oe_i,
    input wire logic [W-1:0] pullup_i,
    input wire logic [W-1:0] ext_en_i,
    input wire logic [W-1:0] ext_i,
    output logic [W-1:0] level_o
);
    // Undriven pins wander so a stale value is never mistaken for data
    logic [W-1:0] float_pat = '0;

    always @(posedge clk_i)
    begin
        float_pat <= ~float_pat;
    end

    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            if (oe_i[i])
                level_o[i] = pad_o_i[i];
            else if (ext_en_i[i])
                level_o[i] = ext_i[i];
            else if (pullup_i[i])
                level_o[i] = 1'b1;
            else
                level_o[i] = float_pat[i];
        end
    end
endmodule : pin_env

`default_nettype wire
